// [hw/power_condition_subcommands.sv]
// device end: decodes and runs the idle-power-condition subcommands
// assumes the issuer holds task-file values while cmd_valid is high
//
// Summary of operation
// - feature 4Ah selects idle power condition subcommands
// - sector count names target condition
// - low nibble zero selects restore settings
// - bit 6 chooses default or saved source
// - default restore loads current from default
// - saved restore loads current from saved
// - restore with save copies current timer
// - restore aborts on bad condition or save
// - low nibble one selects go-to condition
// - go-to halts every enabled timer
// - forced condition entered at once
// - forced condition held until next command
// - go-to aborts on FFh, reserved, feature off
// - low nibble two selects set timer
// - bit 7 picks 100 ms or minute units
// - timer value clamped to limits
// - set timer writes current timer value
// - enable with nonzero timer sets flag
// - enable with zero timer clears flag
// - enable clear clears flag
// - set timer save copies value and flag
`timescale 1ns/1ps
module power_condition_subcommands (
	input wire logic pclk,
	input wire logic presetn,
	task_file_if.device tf,
	input wire logic idle_power_condition_feature,
	output logic forced_valid,
	output logic [7:0] forced_id,
	output logic [pwr_cond_pkg::NCOND-1:0] timer_running,
	output logic [pwr_cond_pkg::NCOND-1:0] cur_timer_en
);
	localparam int N = pwr_cond_pkg::NCOND;
	localparam int TW = pwr_cond_pkg::TIMER_W;
	localparam int SW = pwr_cond_pkg::SCALED_W;

	typedef struct packed {
		pwr_cond_pkg::dev_state_e st;
		logic [7:0] feature;
		logic [7:0] target_condition_id;
		logic [7:0] num;
		logic [15:0] timer;
		logic [7:0] command;
		logic [N-1:0][TW-1:0] cur_t;
		logic [N-1:0] cur_en;
		logic [N-1:0][TW-1:0] sav_t;
		logic [N-1:0] sav_en;
		logic [N-1:0] run;
		logic forced;
		logic [7:0] forced_id;
		logic [7:0] err;
		logic [7:0] sts;
		logic done;
	} dev_s;

	dev_s q;
	dev_s d;

	////////////////////////////////////////////////////////////////////////
	// decode of the captured task file

	logic [N-1:0] sel;
	logic id_all;
	logic id_known;
	logic is_epc;
	logic [3:0] sub;
	logic save;
	logic from_def;
	logic enable;
	logic [SW-1:0] scaled;
	logic [TW-1:0] new_t;
	logic bad_sel;
	logic bad_save;
	logic abort;

	assign is_epc = (q.command == pwr_cond_pkg::CMD_SET_FEATURES) &&
		(q.feature == pwr_cond_pkg::FEAT_EPC);
	assign sub = q.num[3:0];
	assign save = q.num[pwr_cond_pkg::SN_SAVE_BIT];
	assign from_def = q.num[pwr_cond_pkg::SN_DEFAULT_BIT];
	assign enable = q.num[pwr_cond_pkg::SN_ENABLE_BIT];
	assign id_all = (q.target_condition_id == pwr_cond_pkg::ID_ALL);
	assign id_known = id_all || (q.target_condition_id < 8'(N));

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_sel
			assign sel[gi] = id_all ||
				(q.target_condition_id == 8'(gi));
		end
	endgenerate

	assign bad_sel = !id_known ||
		|(sel & ~pwr_cond_pkg::COND_CHANGEABLE);
	assign bad_save = save && |(sel & ~pwr_cond_pkg::COND_SAVABLE);

	// units of a minute scale to 100 ms steps before clamping
	assign scaled = q.num[pwr_cond_pkg::SN_UNITS_BIT] ?
		SW'(q.timer) * pwr_cond_pkg::STEPS_PER_MINUTE :
		SW'(q.timer);
	assign new_t = (scaled > SW'(pwr_cond_pkg::TIMER_MAX)) ?
		pwr_cond_pkg::TIMER_MAX :
		(scaled < SW'(pwr_cond_pkg::TIMER_MIN)) ?
		pwr_cond_pkg::TIMER_MIN : scaled[TW-1:0];

	always_comb begin
		abort = 1'b1;
		if (is_epc && idle_power_condition_feature) begin
			case (sub)
				pwr_cond_pkg::SUB_RESTORE: begin
					abort = bad_sel || bad_save;
				end
				pwr_cond_pkg::SUB_GOTO: begin
					abort = id_all || !id_known;
				end
				pwr_cond_pkg::SUB_SET_TIMER: begin
					abort = bad_sel || bad_save;
				end
				default: begin
					abort = 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		d = q;
		d.done = 1'b0;
		case (q.st)
			pwr_cond_pkg::DEV_IDLE: begin
				if (tf.cmd_valid) begin
					d.feature = tf.feature;
					d.target_condition_id = tf.sect_count;
					d.num = tf.sect_num;
					d.timer = {tf.cyl_high, tf.cyl_low};
					d.command = tf.command;
					d.forced = 1'b0;
					d.run = q.cur_en;
					d.sts = 8'h00;
					d.sts[pwr_cond_pkg::STS_BUSY_BIT] = 1'b1;
					d.st = pwr_cond_pkg::DEV_EXEC;
				end
			end
			pwr_cond_pkg::DEV_EXEC: begin
				d.st = pwr_cond_pkg::DEV_IDLE;
				d.done = 1'b1;
				d.err = 8'h00;
				d.sts = 8'h00;
				d.sts[pwr_cond_pkg::STS_READY_BIT] = 1'b1;
				d.sts[pwr_cond_pkg::STS_DEVICE_FAULT_BIT] = 1'b0;
				if (abort) begin
					d.err[pwr_cond_pkg::ERR_ABORT_BIT] = 1'b1;
					d.sts[pwr_cond_pkg::STS_ERROR_BIT] = 1'b1;
				end else if (sub == pwr_cond_pkg::SUB_GOTO) begin
					d.run = '0;
					d.forced = 1'b1;
					d.forced_id = q.target_condition_id;
				end else begin
					for (int i = 0; i < N; i++) begin
						if (sel[i] && sub == pwr_cond_pkg::SUB_RESTORE) begin
							if (from_def) begin
								d.cur_t[i] = pwr_cond_pkg::DEF_TIMER[i];
								d.cur_en[i] = pwr_cond_pkg::DEF_TIMER_EN[i];
							end else begin
								d.cur_t[i] = q.sav_t[i];
								d.cur_en[i] = q.sav_en[i];
							end
							if (save) begin
								d.sav_t[i] = d.cur_t[i];
							end
						end
						if (sel[i] && sub == pwr_cond_pkg::SUB_SET_TIMER) begin
							d.cur_t[i] = new_t;
							if (enable && new_t != '0) begin
								d.cur_en[i] = 1'b1;
							end else if (enable) begin
								d.cur_en[i] = 1'b0;
							end else begin
								d.cur_en[i] = 1'b0;
							end
							if (save) begin
								d.sav_t[i] = d.cur_t[i];
								d.sav_en[i] = d.cur_en[i];
							end
						end
					end
					d.run = d.cur_en;
				end
			end
			default: begin
				d.st = pwr_cond_pkg::DEV_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.st <= pwr_cond_pkg::DEV_IDLE;
			q.feature <= 8'h00;
			q.target_condition_id <= 8'h00;
			q.num <= 8'h00;
			q.timer <= 16'h0000;
			q.command <= 8'h00;
			q.cur_t <= pwr_cond_pkg::DEF_TIMER;
			q.cur_en <= pwr_cond_pkg::DEF_TIMER_EN;
			q.sav_t <= pwr_cond_pkg::DEF_TIMER;
			q.sav_en <= pwr_cond_pkg::DEF_TIMER_EN;
			q.run <= pwr_cond_pkg::DEF_TIMER_EN;
			q.forced <= 1'b0;
			q.forced_id <= 8'h00;
			q.err <= pwr_cond_pkg::ERR_RESET;
			q.sts <= pwr_cond_pkg::STS_RESET;
			q.done <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign tf.done = q.done;
	assign tf.command_error_flags = q.err;
	assign tf.command_completion_status = q.sts;
	assign forced_valid = q.forced;
	assign forced_id = q.forced_id;
	assign timer_running = q.run;
	assign cur_timer_en = q.cur_en;
endmodule // power_condition_subcommands

// [hw/pwr_cond_pkg.sv]
// constants, types and register map shared by both ends of the link
// assumes one clock pclk, asynchronous active-low reset presetn
package pwr_cond_pkg;
	localparam int NCOND = 4;
	localparam logic [7:0] CMD_SET_FEATURES = 8'hef;
	localparam logic [7:0] FEAT_EPC = 8'h4a;
	localparam logic [3:0] SUB_RESTORE = 4'h0;
	localparam logic [3:0] SUB_GOTO = 4'h1;
	localparam logic [3:0] SUB_SET_TIMER = 4'h2;
	localparam logic [7:0] ID_ALL = 8'hff;
	localparam int SN_UNITS_BIT = 7;
	localparam int SN_DEFAULT_BIT = 6;
	localparam int SN_ENABLE_BIT = 5;
	localparam int SN_SAVE_BIT = 4;
	localparam int ERR_ABORT_BIT = 2;
	localparam int STS_BUSY_BIT = 7;
	localparam int STS_READY_BIT = 6;
	localparam int STS_DEVICE_FAULT_BIT = 5;
	localparam int STS_ERROR_BIT = 0;
	localparam int TIMER_W = 24;
	localparam int SCALED_W = 26;
	localparam logic [TIMER_W-1:0] TIMER_MAX = 24'h3bffc4;
	localparam logic [TIMER_W-1:0] TIMER_MIN = 24'h000000;
	localparam int TIMER_STEP_MS = 100;
	localparam int MINUTE_MS = 60000;
	localparam logic [SCALED_W-1:0] STEPS_PER_MINUTE =
		SCALED_W'(MINUTE_MS / TIMER_STEP_MS);
	localparam logic [NCOND-1:0] COND_CHANGEABLE = 4'hf;
	localparam logic [NCOND-1:0] COND_SAVABLE = 4'hf;
	localparam logic [NCOND-1:0][TIMER_W-1:0] DEF_TIMER = {
		24'h000bb8, 24'h000258, 24'h000032, 24'h000001};
	localparam logic [NCOND-1:0] DEF_TIMER_EN = 4'h1;
	localparam logic [7:0] ERR_RESET = 8'h00;
	localparam logic [7:0] STS_RESET = 8'h40;
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_TIMER = 8'h04;
	localparam logic [7:0] APB_GO = 8'h08;
	localparam logic [7:0] APB_STAT = 8'h0c;
	localparam int STAT_BUSY_BIT = 16;
	localparam int STAT_DONE_BIT = 17;
	typedef enum logic {DEV_IDLE, DEV_EXEC} dev_state_e;
	typedef enum logic [1:0] {HOST_IDLE, HOST_ISSUE, HOST_WAIT} host_state_e;
endpackage

// [hw/task_file_if.sv]
// task-file link between command issuer and power-condition device
// assumes both ends run on the same pclk
`timescale 1ns/1ps
interface task_file_if;
	logic cmd_valid;
	logic [7:0] feature;
	logic [7:0] sect_count;
	logic [7:0] sect_num;
	logic [7:0] cyl_low;
	logic [7:0] cyl_high;
	logic [7:0] command;
	logic done;
	logic [7:0] command_error_flags;
	logic [7:0] command_completion_status;
	modport device (
		input cmd_valid,
		input feature,
		input sect_count,
		input sect_num,
		input cyl_low,
		input cyl_high,
		input command,
		output done,
		output command_error_flags,
		output command_completion_status
	);
	modport host (
		output cmd_valid,
		output feature,
		output sect_count,
		output sect_num,
		output cyl_low,
		output cyl_high,
		output command,
		input done,
		input command_error_flags,
		input command_completion_status
	);
endinterface // task_file_if

// [hw/task_file_issuer.sv]
// host end: APB registers from which software issues task-file commands
// assumes the device answers each command with one done pulse
`timescale 1ns/1ps
module task_file_issuer (
	input wire logic pclk,
	input wire logic presetn,
	task_file_if.host tf,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	typedef struct packed {
		pwr_cond_pkg::host_state_e st;
		logic [31:0] cmd;
		logic [15:0] timer;
		logic [7:0] err;
		logic [7:0] sts;
		logic done_seen;
	} host_s;

	host_s q;
	host_s d;
	logic wr;
	logic rd;

	assign wr = psel && penable && pwrite;
	assign rd = psel && !pwrite;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		d = q;
		if (wr && q.st == pwr_cond_pkg::HOST_IDLE) begin
			case (paddr)
				pwr_cond_pkg::APB_CMD: d.cmd = pwdata;
				pwr_cond_pkg::APB_TIMER: d.timer = pwdata[15:0];
				pwr_cond_pkg::APB_GO: begin
					d.st = pwr_cond_pkg::HOST_ISSUE;
					d.done_seen = 1'b0;
				end
				default: d.st = q.st;
			endcase
		end
		case (q.st)
			pwr_cond_pkg::HOST_ISSUE: d.st = pwr_cond_pkg::HOST_WAIT;
			pwr_cond_pkg::HOST_WAIT: begin
				if (tf.done) begin
					d.st = pwr_cond_pkg::HOST_IDLE;
					d.err = tf.command_error_flags;
					d.sts = tf.command_completion_status;
					d.done_seen = 1'b1;
				end
			end
			pwr_cond_pkg::HOST_IDLE: d.st = d.st;
			default: d.st = pwr_cond_pkg::HOST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.st <= pwr_cond_pkg::HOST_IDLE;
			q.cmd <= 32'h00000000;
			q.timer <= 16'h0000;
			q.err <= pwr_cond_pkg::ERR_RESET;
			q.sts <= pwr_cond_pkg::STS_RESET;
			q.done_seen <= 1'b0;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	always_comb begin
		prdata = 32'h00000000;
		if (rd) begin
			case (paddr)
				pwr_cond_pkg::APB_CMD: prdata = q.cmd;
				pwr_cond_pkg::APB_TIMER: prdata = {16'h0000, q.timer};
				pwr_cond_pkg::APB_STAT: begin
					prdata[7:0] = q.err;
					prdata[15:8] = q.sts;
					prdata[pwr_cond_pkg::STAT_BUSY_BIT] =
						(q.st != pwr_cond_pkg::HOST_IDLE);
					prdata[pwr_cond_pkg::STAT_DONE_BIT] = q.done_seen;
				end
				default: prdata = 32'h00000000;
			endcase
		end
	end

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign tf.cmd_valid = (q.st == pwr_cond_pkg::HOST_ISSUE);
	assign tf.feature = q.cmd[7:0];
	assign tf.sect_count = q.cmd[15:8];
	assign tf.sect_num = q.cmd[23:16];
	assign tf.command = q.cmd[31:24];
	assign tf.cyl_low = q.timer[7:0];
	assign tf.cyl_high = q.timer[15:8];
endmodule // task_file_issuer

// [verification/pwr_cond_assertions.sv]
// checker on the task-file link between issuer and device
// assumes one pclk domain, instanced beside the interface
`timescale 1ns/1ps
module pwr_cond_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cmd_valid,
	input wire logic [7:0] feature,
	input wire logic [7:0] sect_count,
	input wire logic [7:0] sect_num,
	input wire logic [7:0] command,
	input wire logic done,
	input wire logic [7:0] command_error_flags,
	input wire logic [7:0] command_completion_status,
	input wire logic idle_power_condition_feature
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic command_abort_flag;
	assign command_abort_flag = command_error_flags == 8'h04 &&
		command_completion_status == 8'h41;
	////////////////////////////////////////////////////////////////////////
	property p_answer;
		cmd_valid && !command_completion_status[7] |=>
			command_completion_status == 8'h80 ##1 done;
	endproperty
	a_answer: assert property (p_answer)
		else $error("busy then done not seen after command");
	property p_pulse;
		done |=> !done;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("done longer than one cycle");
	property p_feature;
		done && $past(feature, 2) != 8'h4a |-> command_abort_flag;
	endproperty
	a_feature: assert property (p_feature)
		else $error("other feature code not aborted");
	property p_command;
		done && $past(command, 2) != 8'hef |-> command_abort_flag;
	endproperty
	a_command: assert property (p_command)
		else $error("other command not aborted");
	property p_subcode;
		done && $past(sect_num[3:0], 2) > 4'h2 |-> command_abort_flag;
	endproperty
	a_subcode: assert property (p_subcode)
		else $error("unknown subcommand not aborted");
	property p_goto_all;
		done && $past(sect_num[3:0], 2) == 4'h1 &&
			$past(sect_count, 2) == 8'hff |-> command_abort_flag;
	endproperty
	a_goto_all: assert property (p_goto_all)
		else $error("go-to with all ids not aborted");
	property p_reserved;
		done && $past(sect_count, 2) inside {[8'h04:8'hfe]} |-> command_abort_flag;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved id not aborted");
	property p_disabled;
		done && !$past(idle_power_condition_feature, 2) |-> command_abort_flag;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("disabled feature not aborted");
	property p_result;
		done |-> command_abort_flag || (command_error_flags == 8'h00 &&
			command_completion_status == 8'h40);
	endproperty
	a_result: assert property (p_result)
		else $error("bad error or status at done");
	property p_stand;
		!done |-> $stable(command_error_flags);
	endproperty
	a_stand: assert property (p_stand)
		else $error("error flags changed without command");
endmodule // pwr_cond_assertions

// [verification/testbench.sv]
// bench joining issuer and device, software driven over apb
// assumes 20 MHz pclk, apb slave answering through pready
`timescale 1ns/1ps
module testbench;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, feat_en;
	logic forced_valid;
	logic [7:0] paddr, forced_id;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] timer_running, cur_timer_en;
	logic [39:0] ab_tab [7];
	int errors = 0;
	int total_checks = 0;
	localparam logic [31:0] OK = 32'h00024000;
	localparam logic [31:0] AB = 32'h00024104;
	always #25 pclk = ~pclk;
	task_file_if tf_bus();
	power_condition_subcommands power_condition_subcommands_inst (
		.pclk, .presetn, .tf(tf_bus),
		.idle_power_condition_feature(feat_en),
		.forced_valid, .forced_id, .timer_running, .cur_timer_en);
	task_file_issuer task_file_issuer_inst (
		.pclk, .presetn, .tf(tf_bus), .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr);
	pwr_cond_assertions pwr_cond_assertions_inst (
		.pclk, .presetn, .cmd_valid(tf_bus.cmd_valid),
		.feature(tf_bus.feature), .sect_count(tf_bus.sect_count),
		.sect_num(tf_bus.sect_num), .command(tf_bus.command),
		.done(tf_bus.done),
		.command_error_flags(tf_bus.command_error_flags),
		.command_completion_status(tf_bus.command_completion_status),
		.idle_power_condition_feature(feat_en));
	logic [23:0] cur_t2, cur_t3, sav_t3;
	assign cur_t2 = power_condition_subcommands_inst.q.cur_t[2];
	assign cur_t3 = power_condition_subcommands_inst.q.cur_t[3];
	assign sav_t3 = power_condition_subcommands_inst.q.sav_t[3];
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic run(input logic [7:0] c, f, n, s,
		input logic [15:0] t, input logic [31:0] e);
		int k;
		apb(1'b1, pwr_cond_pkg::APB_CMD, {c, s, n, f}, r);
		apb(1'b1, pwr_cond_pkg::APB_TIMER, {16'h0, t}, r);
		apb(1'b1, pwr_cond_pkg::APB_GO, 32'h0, r);
		k = 0;
		do begin
			apb(1'b0, pwr_cond_pkg::APB_STAT, 32'h0, r);
			k++;
		end while (r[17] !== 1'b1 && k < 20);
		check(r, e);
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		test_done();
	end
	initial begin
		ab_tab = '{40'hef4aff0101, 40'hef4a050101, 40'hef4a010301,
			40'hef03012201, 40'hec4a012201, 40'hef4a012200,
			40'hef4a014000};
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		feat_en = 1'b1;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, pwr_cond_pkg::APB_STAT, 32'h0, r);
		check(r, 32'h00004000);
		check(32'(cur_timer_en), 32'h1);
		apb(1'b0, 8'h10, 32'h0, r);
		check(r, 32'h0);
		$display("test reset done");
		run(8'hef, 8'h4a, 8'h01, 8'h22, 16'h0005, OK);
		check(32'(cur_timer_en), 32'h3);
		run(8'hef, 8'h4a, 8'h01, 8'h22, 16'h0000, OK);
		check(32'(cur_timer_en), 32'h1);
		run(8'hef, 8'h4a, 8'h00, 8'h02, 16'h0009, OK);
		check(32'(cur_timer_en), 32'h0);
		run(8'hef, 8'h4a, 8'hff, 8'h40, 16'h0000, OK);
		check(32'(cur_timer_en), 32'h1);
		run(8'hef, 8'h4a, 8'h03, 8'hb2, 16'h0003, OK);
		check(32'(cur_timer_en), 32'h9);
		check(32'(cur_t3), 32'h708);
		check(32'(sav_t3), 32'h708);
		run(8'hef, 8'h4a, 8'h03, 8'h02, 16'h0003, OK);
		check(32'(cur_timer_en), 32'h1);
		check(32'(cur_t3), 32'h3);
		run(8'hef, 8'h4a, 8'h03, 8'h00, 16'h0000, OK);
		check(32'(cur_timer_en), 32'h9);
		check(32'(cur_t3), 32'h708);
		run(8'hef, 8'h4a, 8'h03, 8'h50, 16'h0000, OK);
		check(32'(cur_timer_en), 32'h1);
		check(32'(cur_t3), 32'hbb8);
		check(32'(sav_t3), 32'hbb8);
		run(8'hef, 8'h4a, 8'h03, 8'h00, 16'h0000, OK);
		check(32'(cur_timer_en), 32'h9);
		run(8'hef, 8'h4a, 8'h02, 8'ha2, 16'hffff, OK);
		check(32'(cur_t2), 32'h3bffc4);
		check(32'(cur_timer_en), 32'hd);
		run(8'hef, 8'h4a, 8'h02, 8'h40, 16'h0000, OK);
		check(32'(cur_t2), 32'h258);
		check(32'(cur_timer_en), 32'h9);
		$display("test timers done");
		run(8'hef, 8'h4a, 8'h02, 8'h01, 16'h0000, OK);
		check(32'(forced_valid), 32'h1);
		check(32'(forced_id), 32'h2);
		check(32'(timer_running), 32'h0);
		run(8'hef, 8'h4a, 8'h00, 8'h40, 16'h0000, OK);
		check(32'(forced_valid), 32'h0);
		check(32'(timer_running), 32'h9);
		$display("test go-to done");
		for (int i = 0; i < 7; i++) begin
			feat_en <= ab_tab[i][0];
			run(ab_tab[i][39:32], ab_tab[i][31:24], ab_tab[i][23:16],
				ab_tab[i][15:8], 16'h0004, AB);
			check(32'(cur_timer_en), 32'h9);
		end
		check(32'(forced_valid), 32'h0);
		$display("test aborts done");
		feat_en <= 1'b1;
		run(8'hef, 8'h4a, 8'h01, 8'h01, 16'h0000, OK);
		check(32'(forced_valid), 32'h1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		check(32'(forced_valid), 32'h0);
		check(32'(cur_timer_en), 32'h1);
		presetn <= 1'b1;
		apb(1'b0, pwr_cond_pkg::APB_STAT, 32'h0, r);
		check(r, 32'h00004000);
		$display("test mid-run reset done");
		test_done();
	end
endmodule // testbench
